// >>> hw/run_stop_pkg.sv
// Shared constants, types and helpers for the run/stop mode controller.
package run_stop_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_TASK_ACTIVE = 8'h08;
    localparam logic [7:0] OFF_OUT_IMAGE = 8'h0C;
    localparam logic [7:0] OFF_IN_IMAGE = 8'h10;
    localparam logic [7:0] OFF_MEM_ADDR = 8'h14;
    localparam logic [7:0] OFF_MEM_DATA = 8'h18;

    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam int CTRL_RETAIN_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    localparam int ST_RUN_BIT = 0;
    localparam int ST_CLEAR_BIT = 1;
    localparam int ST_REJECT_BIT = 2;
    localparam int ST_IRQ_BIT = 3;
    localparam int ST_PHASE_LSB = 4;

    typedef enum logic [2:0] {
        PH_IN = 3'h0,
        PH_PROG = 3'h1,
        PH_OUT = 3'h3,
        PH_END = 3'h2,
        PH_CLEAR = 3'h6
    } phase_t;

    typedef enum logic [2:0] {
        CFG_TABLE = 3'h0,
        CFG_INIT = 3'h1,
        CFG_PROG = 3'h2,
        CFG_CHECK = 3'h3,
        CFG_FORCE = 3'h4
    } cfg_kind_t;

    typedef struct packed {
        logic valid;
        cfg_kind_t kind;
    } cfg_req_t;

    typedef struct packed {
        logic accept;
        logic reject;
    } cfg_ans_t;

    // Only checks and bit forcing leave the running program's setup untouched.
    function automatic logic cfgAllowedInRun(input cfg_kind_t k);
        return (k == CFG_CHECK) || (k == CFG_FORCE);
    endfunction : cfgAllowedInRun

endpackage : run_stop_pkg

// >>> hw/data_area_mem.sv
// Program data memory with registered read port and write-through.
`timescale 1ns/1ns
module data_area_mem #(
    parameter int DEPTH = 64,
    parameter int WIDTH = 32,
    parameter int AW = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Write-through keeps a read of the address just written from seeing stale data.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= '0;
        end else if (we && (waddr == raddr)) begin
            rdata <= wdata;
        end else begin
            rdata <= mem[raddr];
        end
    end

endmodule : data_area_mem

// >>> hw/run_stop_mode_controller.sv
// Run/stop mode controller with scan sequencing, task and interrupt gating.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ns
// Notes on behaviour
// - The user program runs only in RUN mode and never in STOP mode.
// - In STOP mode table and program downloads, config init, program checks and bit forcing are accepted.
// - In RUN mode module table download and configuration initialization are rejected.
// - In STOP mode external outputs go off unless output retention is set, which holds the last state.
// - In RUN mode the program's output image decides the external outputs.
// - In STOP mode no cyclic loop task executes.
// - In STOP mode no interrupt task starts even when its condition occurs.
// - In RUN mode loop tasks not currently executing are held halted.
// - In RUN mode a loop task runs when it is active or an enable instruction for it was executed.
// - In RUN mode a loop task is skipped when inactive or after a disable instruction for it.
// - In RUN mode an interrupt task runs whenever its condition is met.
// - On STOP to RUN the non-latched area is cleared or kept according to the clear setting.
// - The latched area is never cleared, and RUN to STOP clears nothing.
// - Each scan refreshes inputs before the program and outputs after it.
// - An interrupt starts only after the current instruction completes, saving and later resuming its position.
module run_stop_mode_controller
    import run_stop_pkg::*;
#(
    parameter int NUM_TASKS = 8,
    parameter int NUM_IRQ = 4,
    parameter int IO_W = 16,
    parameter int POS_W = 16,
    parameter int MEM_DEPTH = 64,
    parameter int LATCH_BASE = 48
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdata,
    // Configuration tool
    input wire cfg_req_t cfgReq,
    output cfg_ans_t cfgAns,
    // I/O modules
    input wire logic [IO_W-1:0] inPins,
    output logic [IO_W-1:0] extOut,
    // Program executor
    input wire logic programDone,
    input wire logic instrDone,
    input wire logic [POS_W-1:0] nextPos,
    input wire logic irqDone,
    input wire logic [NUM_TASKS-1:0] taskEnableInstr,
    input wire logic [NUM_TASKS-1:0] taskDisableInstr,
    input wire logic [NUM_IRQ-1:0] irqCond,
    output logic programRun,
    output logic [NUM_TASKS-1:0] taskRun,
    output logic irqStart,
    output logic [NUM_IRQ-1:0] irqGrant,
    output logic irqResume,
    output logic [POS_W-1:0] resumePos,
    output logic runMode,
    output logic scanEnd
);

    localparam int MA_W = $clog2(MEM_DEPTH);

    function automatic logic [NUM_IRQ-1:0] lowestOne(input logic [NUM_IRQ-1:0] x);
        return x & (~x + NUM_IRQ'(1));
    endfunction : lowestOne

    phase_t phase_q, phase_d;
    logic mode_q, mode_d;
    logic [MA_W-1:0] clearAddr_q, clearAddr_d;
    logic [IO_W-1:0] inImage_q, inImage_d;
    logic [IO_W-1:0] extOut_q, extOut_d;
    logic [NUM_TASKS-1:0] taskOn_q, taskOn_d;
    logic [NUM_TASKS-1:0] taskRun_q, taskRun_d;
    logic [NUM_IRQ-1:0] irqPend_q, irqPend_d;
    logic [NUM_IRQ-1:0] irqGrant_q, irqGrant_d;
    logic irqActive_q, irqActive_d;
    logic irqStart_q, irqStart_d;
    logic irqResume_q, irqResume_d;
    logic [POS_W-1:0] savedPos_q, savedPos_d;
    logic [POS_W-1:0] resumePos_q, resumePos_d;
    logic programRun_q, programRun_d;
    logic scanEnd_q, scanEnd_d;

    logic [2:0] ctrl_q, ctrl_d;
    logic [IO_W-1:0] outImage_q, outImage_d;
    logic [MA_W-1:0] memAddr_q, memAddr_d;
    logic reject_q, reject_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    cfg_ans_t cfgAns_q, cfgAns_d;

    logic wrTaskActive;
    logic wrMemData;
    logic memWe;
    logic [MA_W-1:0] memWaddr;
    logic [DATA_W-1:0] memWdata;
    logic [MA_W-1:0] memRaddr;
    logic [DATA_W-1:0] memRdata;
    logic [NUM_IRQ-1:0] irqSeen;

    assign wrTaskActive = regWr && (regAddr == OFF_TASK_ACTIVE);
    assign wrMemData = regWr && (regAddr == OFF_MEM_DATA);

    // The clear walk owns the write port; software writes to the data area are dropped meanwhile.
    always_comb begin
        if (phase_q == PH_CLEAR) begin
            memWe = 1'b1;
            memWaddr = clearAddr_q;
            memWdata = '0;
        end else begin
            memWe = wrMemData;
            memWaddr = memAddr_q;
            memWdata = regWdata;
        end
        memRaddr = (regWr && (regAddr == OFF_MEM_ADDR)) ? regWdata[MA_W-1:0] : memAddr_q;
    end

    data_area_mem #(
        .DEPTH(MEM_DEPTH),
        .WIDTH(DATA_W),
        .AW(MA_W)
    ) dataArea (
        .clk(clk),
        .rst(rst),
        .we(memWe),
        .waddr(memWaddr),
        .wdata(memWdata),
        .raddr(memRaddr),
        .rdata(memRdata)
    );

    // Scan sequencer, tasks and interrupts.
    always_comb begin
        phase_d = phase_q;
        mode_d = mode_q;
        clearAddr_d = clearAddr_q;
        inImage_d = inImage_q;
        extOut_d = extOut_q;
        taskOn_d = taskOn_q;
        irqActive_d = irqActive_q;
        irqStart_d = 1'b0;
        irqGrant_d = '0;
        irqResume_d = 1'b0;
        savedPos_d = savedPos_q;
        resumePos_d = resumePos_q;
        scanEnd_d = 1'b0;
        case (phase_q)
            PH_IN: begin
                inImage_d = inPins;
                phase_d = PH_PROG;
            end
            PH_PROG: begin
                if (!mode_q) begin
                    phase_d = PH_OUT;
                end else if (programDone && !irqActive_q) begin
                    phase_d = PH_OUT;
                end
            end
            PH_OUT: begin
                if (mode_q) begin
                    extOut_d = outImage_q;
                end else if (!ctrl_q[CTRL_RETAIN_BIT]) begin
                    extOut_d = '0;
                end
                phase_d = PH_END;
            end
            PH_END: begin
                scanEnd_d = 1'b1;
                phase_d = PH_IN;
                if (ctrl_q[CTRL_RUN_BIT] && !mode_q) begin
                    if (ctrl_q[CTRL_CLEAR_BIT]) begin
                        phase_d = PH_CLEAR;
                        clearAddr_d = '0;
                    end else begin
                        mode_d = 1'b1;
                    end
                end else if (!ctrl_q[CTRL_RUN_BIT] && mode_q) begin
                    mode_d = 1'b0;
                end
            end
            PH_CLEAR: begin
                // Only the area below the latched base is wiped.
                if (clearAddr_q == MA_W'(LATCH_BASE - 1)) begin
                    mode_d = 1'b1;
                    phase_d = PH_IN;
                end else begin
                    clearAddr_d = clearAddr_q + MA_W'(1);
                end
            end
            default: begin
                phase_d = PH_IN;
            end
        endcase
        if (wrTaskActive) begin
            taskOn_d = regWdata[NUM_TASKS-1:0];
        end
        if (mode_q && (phase_q == PH_PROG)) begin
            taskOn_d = (taskOn_d | taskEnableInstr) & ~taskDisableInstr;
        end
        programRun_d = mode_d && (phase_d == PH_PROG);
        taskRun_d = programRun_d ? taskOn_d : '0;
        irqSeen = mode_q ? (irqPend_q | irqCond) : '0;
        irqPend_d = irqSeen;
        if (mode_q && (phase_q == PH_PROG) && !irqActive_q && instrDone && (irqSeen != '0)) begin
            irqGrant_d = lowestOne(irqSeen);
            irqStart_d = 1'b1;
            irqActive_d = 1'b1;
            savedPos_d = nextPos;
            irqPend_d = (irqPend_q & ~irqGrant_d) | irqCond;
        end
        if (irqActive_q && irqDone) begin
            irqActive_d = 1'b0;
            irqResume_d = 1'b1;
            resumePos_d = savedPos_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            phase_q <= PH_IN;
            mode_q <= 1'b0;
            clearAddr_q <= '0;
            inImage_q <= '0;
            extOut_q <= '0;
            taskOn_q <= '0;
            taskRun_q <= '0;
            irqPend_q <= '0;
            irqGrant_q <= '0;
            irqActive_q <= 1'b0;
            irqStart_q <= 1'b0;
            irqResume_q <= 1'b0;
            savedPos_q <= '0;
            resumePos_q <= '0;
            programRun_q <= 1'b0;
            scanEnd_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            mode_q <= mode_d;
            clearAddr_q <= clearAddr_d;
            inImage_q <= inImage_d;
            extOut_q <= extOut_d;
            taskOn_q <= taskOn_d;
            taskRun_q <= taskRun_d;
            irqPend_q <= irqPend_d;
            irqGrant_q <= irqGrant_d;
            irqActive_q <= irqActive_d;
            irqStart_q <= irqStart_d;
            irqResume_q <= irqResume_d;
            savedPos_q <= savedPos_d;
            resumePos_q <= resumePos_d;
            programRun_q <= programRun_d;
            scanEnd_q <= scanEnd_d;
        end
    end

    // Register port and configuration requests.
    always_comb begin
        ctrl_d = ctrl_q;
        outImage_d = outImage_q;
        memAddr_d = memAddr_q;
        reject_d = reject_q;
        rdata_d = '0;
        cfgAns_d = '0;
        if (regWr) begin
            case (regAddr)
                OFF_CTRL: ctrl_d = regWdata[2:0];
                OFF_OUT_IMAGE: outImage_d = regWdata[IO_W-1:0];
                OFF_MEM_ADDR: memAddr_d = regWdata[MA_W-1:0];
                OFF_STATUS: begin
                    if (regWdata[ST_REJECT_BIT]) begin
                        reject_d = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // A rejection arriving with the clear still sets the flag.
        if (cfgReq.valid) begin
            if (!mode_q || cfgAllowedInRun(cfgReq.kind)) begin
                cfgAns_d.accept = 1'b1;
            end else begin
                cfgAns_d.reject = 1'b1;
                reject_d = 1'b1;
            end
        end
        if (regRd) begin
            case (regAddr)
                OFF_CTRL: rdata_d[2:0] = ctrl_q;
                OFF_STATUS: begin
                    rdata_d[ST_RUN_BIT] = mode_q;
                    rdata_d[ST_CLEAR_BIT] = (phase_q == PH_CLEAR);
                    rdata_d[ST_REJECT_BIT] = reject_q;
                    rdata_d[ST_IRQ_BIT] = irqActive_q;
                    rdata_d[ST_PHASE_LSB +: 3] = phase_q;
                end
                OFF_TASK_ACTIVE: rdata_d[NUM_TASKS-1:0] = taskOn_q;
                OFF_OUT_IMAGE: rdata_d[IO_W-1:0] = outImage_q;
                OFF_IN_IMAGE: rdata_d[IO_W-1:0] = inImage_q;
                OFF_MEM_ADDR: rdata_d[MA_W-1:0] = memAddr_q;
                OFF_MEM_DATA: rdata_d = memRdata;
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= CTRL_RESET;
            outImage_q <= '0;
            memAddr_q <= '0;
            reject_q <= 1'b0;
            rdata_q <= '0;
            cfgAns_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            outImage_q <= outImage_d;
            memAddr_q <= memAddr_d;
            reject_q <= reject_d;
            rdata_q <= rdata_d;
            cfgAns_q <= cfgAns_d;
        end
    end

    assign regRdata = rdata_q;
    assign cfgAns = cfgAns_q;
    assign extOut = extOut_q;
    assign programRun = programRun_q;
    assign taskRun = taskRun_q;
    assign irqStart = irqStart_q;
    assign irqGrant = irqGrant_q;
    assign irqResume = irqResume_q;
    assign resumePos = resumePos_q;
    assign runMode = mode_q;
    assign scanEnd = scanEnd_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_stop_no_program: assert property (!mode_q |-> !programRun_q && !irqStart_q)
        else $error("program or interrupt active in stop mode");
    a_stop_accepts_cfg: assert property (cfgReq.valid && !mode_q |=> cfgAns_q.accept && !cfgAns_q.reject)
        else $error("configuration request refused in stop mode");
    a_run_rejects_cfg: assert property (cfgReq.valid && mode_q && !cfgAllowedInRun(cfgReq.kind)
        |=> cfgAns_q.reject && !cfgAns_q.accept && reject_q)
        else $error("configuration change accepted in run mode");
    a_stop_outputs_off: assert property (phase_q == PH_OUT && !mode_q && !ctrl_q[CTRL_RETAIN_BIT]
        |=> extOut_q == '0)
        else $error("outputs not off in stop mode");
    a_run_outputs_image: assert property (phase_q == PH_OUT && mode_q |=> extOut_q == $past(outImage_q))
        else $error("outputs do not follow program image");
    a_stop_no_tasks: assert property (!mode_q |-> taskRun_q == '0)
        else $error("loop task running in stop mode");
    a_task_disable_wins: assert property (mode_q && phase_q == PH_PROG && !wrTaskActive
        |=> (taskRun_q & $past(taskDisableInstr)) == '0)
        else $error("disabled loop task still running");
    a_irq_after_instr: assert property (irqStart_q |-> $past(instrDone) && savedPos_q == $past(nextPos)
        && irqActive_q ##1 !irqStart_q)
        else $error("interrupt started without instruction boundary");
    a_in_before_prog: assert property (phase_q == PH_IN |=> phase_q == PH_PROG && inImage_q == $past(inPins))
        else $error("input refresh did not precede program");
    a_clear_on_run: assert property (phase_q == PH_END && !mode_q && ctrl_q[CTRL_RUN_BIT] && ctrl_q[CTRL_CLEAR_BIT]
        |=> phase_q == PH_CLEAR && !mode_q)
        else $error("selected clear skipped on stop to run");
    a_mode_at_boundary: assert property ($changed(mode_q) |-> $past(phase_q) == PH_END
        || $past(phase_q) == PH_CLEAR)
        else $error("mode changed inside a scan");

endmodule : run_stop_mode_controller

// >>> test/exec_model.sv
// Behavioural program executor and input module facing the mode controller.
`timescale 1ns/1ns
module exec_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Controller side
    input wire logic programRun,
    input wire logic irqStart,
    output logic programDone,
    output logic instrDone,
    output logic [15:0] nextPos,
    output logic irqDone,
    output logic [15:0] inPins,
    // Test settings
    input wire logic [15:0] inVal,
    input wire logic [7:0] progLen,
    input wire logic [7:0] irqLen
);
    logic irqBusy;
    logic [7:0] progCnt;
    logic [7:0] irqCnt;
    // Time spent inside an interrupt does not count towards the program body.
    assign programDone = programRun && !irqBusy && (progCnt >= progLen);
    assign inPins = inVal;
    always @(posedge clk) begin
        if (rst) begin
            instrDone <= 1'b0;
            irqDone <= 1'b0;
            irqBusy <= 1'b0;
            nextPos <= 16'h0000;
            progCnt <= 8'h00;
            irqCnt <= 8'h00;
        end else begin
            instrDone <= programRun && !irqBusy && !irqStart;
            irqDone <= 1'b0;
            if (instrDone) begin
                nextPos <= nextPos + 16'h0001;
            end
            progCnt <= !programRun ? 8'h00 : (irqBusy ? progCnt : progCnt + 8'h01);
            if (irqStart) begin
                irqBusy <= 1'b1;
                irqCnt <= 8'h00;
            end else if (irqBusy) begin
                irqCnt <= irqCnt + 8'h01;
                if (irqCnt == irqLen) begin
                    irqDone <= 1'b1;
                    irqBusy <= 1'b0;
                end
            end
        end
    end
endmodule : exec_model

// >>> test/tb.sv
// Self-checking testbench for the run/stop mode controller.
`timescale 1ns/1ns
module tb;
    import run_stop_pkg::*;
    logic clk, rst, regWr, regRd, programDone, instrDone, irqDone, irqStart, irqResume;
    logic programRun, runMode, scanEnd;
    logic [7:0] regAddr, progLen, irqLen, taskRun, taskEnableInstr, taskDisableInstr;
    logic [31:0] regWdata, regRdata;
    logic [15:0] inPins, extOut, nextPos, resumePos, inVal, lastPos, saved;
    logic [3:0] irqCond, irqGrant;
    cfg_req_t cfgReq;
    cfg_ans_t cfgAns;
    int badCount = 0;
    int numChecks = 0;
    int k;

    run_stop_mode_controller i_run_stop_mode_controller (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cfgReq(cfgReq),
        .cfgAns(cfgAns), .inPins(inPins), .extOut(extOut), .programDone(programDone),
        .instrDone(instrDone), .nextPos(nextPos), .irqDone(irqDone), .taskEnableInstr(taskEnableInstr),
        .taskDisableInstr(taskDisableInstr), .irqCond(irqCond), .programRun(programRun),
        .taskRun(taskRun), .irqStart(irqStart), .irqGrant(irqGrant), .irqResume(irqResume),
        .resumePos(resumePos), .runMode(runMode), .scanEnd(scanEnd));
    exec_model i_exec_model (.clk(clk), .rst(rst), .programRun(programRun), .irqStart(irqStart),
        .programDone(programDone), .instrDone(instrDone), .nextPos(nextPos), .irqDone(irqDone),
        .inPins(inPins), .inVal(inVal), .progLen(progLen), .irqLen(irqLen));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) lastPos <= nextPos;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            badCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk(regRdata & m, e);
    endtask : rdChk
    task automatic memWr(input logic [31:0] a, input logic [31:0] d);
        wr(OFF_MEM_ADDR, a);
        wr(OFF_MEM_DATA, d);
    endtask : memWr
    task automatic memChk(input logic [31:0] a, input logic [31:0] e);
        wr(OFF_MEM_ADDR, a);
        rdChk(OFF_MEM_DATA, 32'hFFFFFFFF, e);
    endtask : memChk
    task automatic cfgChk(input int kd, input logic [1:0] e);
        @(posedge clk);
        cfgReq <= '{valid: 1'b1, kind: cfg_kind_t'(kd)};
        @(posedge clk);
        cfgReq.valid <= 1'b0;
        #1 chk({30'h0, cfgAns}, {30'h0, e});
    endtask : cfgChk
    // Waits are bounded so a stuck sequencer shows up as a mismatch, not a hang.
    task automatic waitOn(input int sel, input logic val);
        logic hit;
        int n;
        hit = 1'b0;
        for (n = 0; n < 500 && !hit; n++) begin
            @(posedge clk);
            #1;
            case (sel)
                0: hit = (runMode === val);
                1: hit = (programRun === val);
                2: hit = (scanEnd === val);
                3: hit = (irqStart === val);
                default: hit = (irqResume === val);
            endcase
        end
        chk({31'h0, hit}, 32'h1);
    endtask : waitOn

    task automatic testStop();
        chk({29'h0, runMode, programRun, irqStart}, 32'h0);
        rdChk(OFF_CTRL, 32'h7, 32'h0);
        wr(OFF_OUT_IMAGE, 32'h5A3C);
        wr(OFF_TASK_ACTIVE, 32'h05);
        memWr(32'h0, 32'hCAFE0001);
        memWr(32'h30, 32'hBEEF0030);
        for (k = 0; k < 5; k++) cfgChk(k, 2'b10);
        repeat (20) begin
            @(posedge clk);
            irqCond <= 4'hF;
            #1 chk({6'h0, programRun, taskRun, irqStart, extOut}, 32'h0);
        end
        @(posedge clk);
        irqCond <= 4'h0;
        rdChk(OFF_IN_IMAGE, 32'hFFFF, 32'h1234);
        $display("test stop finished");
    endtask : testStop

    task automatic testRun();
        wr(OFF_CTRL, 32'h3);
        waitOn(0, 1'b1);
        rdChk(OFF_STATUS, 32'h3, 32'h1);
        memChk(32'h0, 32'h0);
        memChk(32'h30, 32'hBEEF0030);
        waitOn(1, 1'b1);
        chk({24'h0, taskRun}, 32'h05);
        waitOn(2, 1'b1);
        chk({16'h0, extOut}, 32'h5A3C);
        for (k = 0; k < 5; k++) cfgChk(k, (k >= 3) ? 2'b10 : 2'b01);
        rdChk(OFF_STATUS, 32'h4, 32'h4);
        wr(OFF_STATUS, 32'h4);
        rdChk(OFF_STATUS, 32'h4, 32'h0);
        $display("test run finished");
    endtask : testRun

    task automatic testTasks();
        // Start from a fresh program phase so the instruction pulses land inside it.
        waitOn(1, 1'b0);
        waitOn(1, 1'b1);
        @(posedge clk);
        taskEnableInstr <= 8'h02;
        taskDisableInstr <= 8'h01;
        @(posedge clk);
        taskEnableInstr <= 8'h00;
        taskDisableInstr <= 8'h00;
        @(posedge clk);
        #1 chk({24'h0, taskRun}, 32'h06);
        rdChk(OFF_TASK_ACTIVE, 32'hFF, 32'h06);
        waitOn(1, 1'b0);
        chk({24'h0, taskRun}, 32'h0);
        $display("test tasks finished");
    endtask : testTasks

    task automatic testIrq();
        waitOn(1, 1'b1);
        @(posedge clk);
        irqCond <= 4'h6;
        @(posedge clk);
        irqCond <= 4'h0;
        #1 chk({31'h0, irqStart}, 32'h1);
        saved = lastPos;
        chk({28'h0, irqGrant}, 32'h2);
        waitOn(4, 1'b1);
        chk({16'h0, resumePos}, {16'h0, saved});
        // A condition seen in its own grant cycle stays pending, so that line is served once more.
        waitOn(3, 1'b1);
        chk({28'h0, irqGrant}, 32'h2);
        waitOn(4, 1'b1);
        waitOn(3, 1'b1);
        chk({28'h0, irqGrant}, 32'h4);
        waitOn(4, 1'b1);
        $display("test irq finished");
    endtask : testIrq

    task automatic testStopRetain();
        waitOn(1, 1'b1);
        wr(OFF_CTRL, 32'h4);
        chk({31'h0, runMode}, 32'h1);
        waitOn(0, 1'b0);
        chk({16'h0, extOut}, 32'h5A3C);
        wr(OFF_OUT_IMAGE, 32'h0F0F);
        waitOn(2, 1'b1);
        waitOn(2, 1'b1);
        chk({16'h0, extOut}, 32'h5A3C);
        wr(OFF_CTRL, 32'h0);
        waitOn(2, 1'b1);
        waitOn(2, 1'b1);
        chk({16'h0, extOut}, 32'h0);
        memChk(32'h30, 32'hBEEF0030);
        memWr(32'h0, 32'h11112222);
        wr(OFF_CTRL, 32'h1);
        waitOn(0, 1'b1);
        memChk(32'h0, 32'h11112222);
        waitOn(1, 1'b1);
        waitOn(2, 1'b1);
        chk({16'h0, extOut}, 32'h0F0F);
        $display("test stop retain finished");
    endtask : testStopRetain

    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : giveVerdict

    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        $display("timeout reached");
        giveVerdict();
    end

    initial begin
        rst = 1'b1;
        regAddr = 8'h00;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        cfgReq = '0;
        taskEnableInstr = 8'h00;
        taskDisableInstr = 8'h00;
        irqCond = 4'h0;
        inVal = 16'h1234;
        progLen = 8'h14;
        irqLen = 8'h05;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        testStop();
        testRun();
        testTasks();
        testIrq();
        testStopRetain();
        giveVerdict();
    end
endmodule : tb
